/* File: sbw_pkg.sv */
// Purpose: shared constants and types for the serial break / wake / sync master block
// Assumes: classic wishbone, 32-bit data, 8-bit registers in the low byte
// Notes:   all offsets are byte addresses of aligned words
package sbw_pkg;
    // =========================================================
    // register offsets
    localparam logic [5:0] ADDR_INTCTL  = 6'h00; // global_interrupt_control
    localparam logic [5:0] ADDR_FLAGS   = 6'h04; // peripheral_flags_one
    localparam logic [5:0] ADDR_ENABLES = 6'h08; // peripheral_enables_one
    localparam logic [5:0] ADDR_PRIO    = 6'h0c; // peripheral_priority_one
    localparam logic [5:0] ADDR_RXCTL   = 6'h10; // receive_control_status
    localparam logic [5:0] ADDR_TXBUF   = 6'h14; // transmit_buffer
    localparam logic [5:0] ADDR_TXCTL   = 6'h18; // transmit_control_status
    localparam logic [5:0] ADDR_BAUDCTL = 6'h1c; // baud_control
    localparam logic [5:0] ADDR_DIVHI   = 6'h20; // baud_divisor_high
    localparam logic [5:0] ADDR_DIVLO   = 6'h24; // baud_divisor_low
    localparam logic [5:0] ADDR_RXBUF   = 6'h28; // receive_buffer
    // =========================================================
    // field positions
    localparam int TX_CLOCK_SOURCE_SELECT  = 7; // clock_source_select
    localparam int TX_NINE  = 6; // nine_bit_transmit_select
    localparam int TX_EN    = 5; // transmit_enable
    localparam int TX_SYNC  = 4; // synchronous select
    localparam int TX_BRK   = 3; // send_break_request
    localparam int TX_EMPTY = 1; // shift_empty_status
    localparam int TX_D9    = 0; // ninth_transmit_bit
    localparam int RC_PEN   = 7; // port_enable
    localparam int BC_IDLE  = 6; // receiver_idle_status
    localparam int BC_POL   = 4; // clock_polarity_select
    localparam int BC_WIDE  = 3; // wide_divisor_select
    localparam int BC_WAKE  = 1; // wake_on_edge_enable
    localparam int BC_ABD   = 0; // auto_baud_enable
    localparam int FL_RXF   = 5; // receive_int_flag
    localparam int FL_TXF   = 4; // transmit_int_flag
    // =========================================================
    // reset values and counts
    localparam logic [7:0] RST_TXCTL   = 8'h02;
    localparam logic [7:0] RST_ZERO    = 8'h00;
    localparam logic [3:0] BREAK_ZEROS = 4'hc; // twelve zero bits
    // =========================================================
    // types
    typedef enum logic [2:0] {
        SBW_IDLE  = 3'b000,
        SBW_LOAD  = 3'b001,
        SBW_SHIFT = 3'b011,
        SBW_BREAK = 3'b010,
        SBW_STOP  = 3'b110
    } sbw_tx_e;
    typedef struct packed {
        logic [5:0] adr;
        logic       we;
        logic [7:0] dat;
    } sbw_req_s;
endpackage

/* File: sbw_baud.sv */
// Purpose: baud rate divider giving one-cycle enable pulses
// Assumes: divisor static while running
// Notes:   8-bit mode uses only the low byte
`timescale 1ns/1ps
module sbw_baud #(
    parameter int W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         run_i,  // count only while running
    input  wire logic         wide_i, // use 16-bit divisor
    input  wire logic [W-1:0] div_i,
    output logic              tick_o  // one pulse per divisor-plus-one clocks while running
);
    if (W < 8) begin : gen_chk
        $error("divisor too narrow");
    end
    logic [W-1:0] cnt_q;
    logic [W-1:0] lim;
    assign lim = wide_i ? div_i : {{(W-8){1'b0}}, div_i[7:0]};
    // =========================================================
    // down counter, reload on zero
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i || tick_o) begin
            cnt_q <= lim;
        end else begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
    // tick straight from the count, so a frame's first bit lasts a full period
    assign tick_o = run_i && cnt_q == '0;
endmodule

/* File: sbw_sync.sv */
// Purpose: two-flop synchroniser bank for pin inputs
// Assumes: inputs asynchronous to clk_i
// Notes:   only q_o may be read by logic
`timescale 1ns/1ps
module sbw_sync #(
    parameter int N = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [N-1:0] d_i,
    output logic      [N-1:0] q_o
);
    logic [N-1:0] meta_q; // first stage, read only by second
    // =========================================================
    // per-bit two stage chain, idle line is high
    genvar g;
    for (g = 0; g < N; g++) begin : gen_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta_q[g] <= 1'b1;
                q_o[g]    <= 1'b1;
            end else begin
                meta_q[g] <= d_i[g];
                q_o[g]    <= meta_q[g];
            end
        end
    end
endmodule

/* File: sbw_top.sv */
// Purpose: serial port break send, wake on edge and sync master transmit
// Assumes: one 100 MHz clock, synchronous active-high reset, wishbone slave
// Notes:   async receive data path beyond wake is not built
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module sbw_top #(
    parameter int DIV_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [5:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        rx_i,      // receive_data_line pin input
    output logic             tx_o,      // async data / shift_clock_line
    output logic             dt_o,      // sync_data_line drive value
    output logic             dt_oe_o,   // sync_data_line enable
    output logic             ck_oe_o,   // tx pin enable
    output logic             rx_int_o,  // receive_int_flag level
    output logic             tx_int_o   // transmit_int_flag level
);
    if (DIV_W != 16) begin : gen_chk
        $error("divisor pair is 16 bits");
    end
    // =========================================================
    // registers
    logic [7:0] intctl_q, enables_q, prio_q, rxctl_q, txctl_q, baudctl_q;
    logic [7:0] divhi_q, divlo_q;
    logic [7:0] txbuf_q;       // transmit_buffer contents
    logic       txbuf_full_q;  // buffer holds unsent word
    logic       rxf_q;         // receive_int_flag
    logic [8:0] shift_q;       // transmit_shifter
    logic [3:0] bitcnt_q;      // bits left in frame
    logic       half_q;        // sync clock phase
    logic       brk_frame_q;   // current frame is a break
    sbw_pkg::sbw_tx_e st_q;
    sbw_pkg::sbw_req_s req;
    // =========================================================
    // decode
    logic wr, rd, sync_m, async_m, tick, rx_s, rx_d_q, fall, rise;
    logic load_now;
    assign req    = '{adr: adr_i, we: we_i, dat: dat_i[7:0]};
    assign wr     = cyc_i && stb_i && req.we && !ack_o && sel_i[0];
    assign rd     = cyc_i && stb_i && !req.we && !ack_o;
    // sync master selects the pins as clock and data
    assign sync_m = txctl_q[sbw_pkg::TX_CLOCK_SOURCE_SELECT] && txctl_q[sbw_pkg::TX_SYNC]
                    && rxctl_q[sbw_pkg::RC_PEN];
    assign async_m = !txctl_q[sbw_pkg::TX_SYNC] && rxctl_q[sbw_pkg::RC_PEN];
    // shifter loads only once idle and a word waits
    assign load_now = (st_q == sbw_pkg::SBW_IDLE) && txbuf_full_q
                      && txctl_q[sbw_pkg::TX_EN] && (sync_m || async_m);
    // =========================================================
    // helpers
    sbw_sync #(.N(1)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (rx_i),
        .q_o   (rx_s)
    );
    // one tick per half period in sync, per bit otherwise
    sbw_baud #(.W(DIV_W)) u_baud (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (st_q != sbw_pkg::SBW_IDLE),
        .wide_i (baudctl_q[sbw_pkg::BC_WIDE]),
        .div_i  ({divhi_q, divlo_q}),
        .tick_o (tick)
    );
    // =========================================================
    // receive line edge detect on synchronised copy
    always_ff @(posedge clk_i) begin
        if (rst_i) rx_d_q <= 1'b1;
        else       rx_d_q <= rx_s;
    end
    assign fall = rx_d_q && !rx_s;
    assign rise = !rx_d_q && rx_s;
    // =========================================================
    // wishbone ack, one cycle after request, dropped next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) ack_o <= 1'b0;
        else       ack_o <= cyc_i && stb_i && !ack_o;
    end
    // =========================================================
    // read mux, unmapped reads zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= '0;
        end else if (rd) begin
            case (req.adr)
                sbw_pkg::ADDR_INTCTL:  dat_o <= {24'h0, intctl_q};
                sbw_pkg::ADDR_FLAGS:   dat_o <= {24'h0, 2'b00, rxf_q, !txbuf_full_q, 4'h0};
                sbw_pkg::ADDR_ENABLES: dat_o <= {24'h0, enables_q};
                sbw_pkg::ADDR_PRIO:    dat_o <= {24'h0, prio_q};
                sbw_pkg::ADDR_RXCTL:   dat_o <= {24'h0, rxctl_q};
                sbw_pkg::ADDR_TXBUF:   dat_o <= {24'h0, txbuf_q};
                sbw_pkg::ADDR_TXCTL:   dat_o <= {24'h0, txctl_q[7:2],
                                                 st_q == sbw_pkg::SBW_IDLE, txctl_q[0]};
                sbw_pkg::ADDR_BAUDCTL: dat_o <= {24'h0, 1'b0,
                                                 !baudctl_q[sbw_pkg::BC_WAKE] && rx_s,
                                                 1'b0, baudctl_q[4:3], 1'b0, baudctl_q[1:0]};
                sbw_pkg::ADDR_DIVHI:   dat_o <= {24'h0, divhi_q};
                sbw_pkg::ADDR_DIVLO:   dat_o <= {24'h0, divlo_q};
                sbw_pkg::ADDR_RXBUF:   dat_o <= '0; // dummy data after wake
                default:               dat_o <= '0;
            endcase
        end
    end
    // =========================================================
    // plain control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            intctl_q  <= sbw_pkg::RST_ZERO;
            enables_q <= sbw_pkg::RST_ZERO;
            prio_q    <= sbw_pkg::RST_ZERO;
            rxctl_q   <= sbw_pkg::RST_ZERO;
            divhi_q   <= sbw_pkg::RST_ZERO;
            divlo_q   <= sbw_pkg::RST_ZERO;
        end else if (wr) begin
            case (req.adr)
                sbw_pkg::ADDR_INTCTL:  intctl_q  <= req.dat;
                sbw_pkg::ADDR_ENABLES: enables_q <= req.dat;
                sbw_pkg::ADDR_PRIO:    prio_q    <= req.dat;
                sbw_pkg::ADDR_RXCTL:   rxctl_q   <= req.dat;
                sbw_pkg::ADDR_DIVHI:   divhi_q   <= req.dat;
                sbw_pkg::ADDR_DIVLO:   divlo_q   <= req.dat;
                default: ;
            endcase
        end
    end
    // =========================================================
    // transmit control, break bit self clears after stop bit
    logic brk_done;
    assign brk_done = (st_q == sbw_pkg::SBW_STOP) && tick && brk_frame_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txctl_q <= sbw_pkg::RST_TXCTL;
        end else begin
            if (wr && req.adr == sbw_pkg::ADDR_TXCTL)
                txctl_q <= {req.dat[7:2], 1'b0, req.dat[0]};
            if (brk_done)
                txctl_q[sbw_pkg::TX_BRK] <= 1'b0;
        end
    end
    // =========================================================
    // baud control; wake enable falls on rising edge after wake
    logic wake_seen_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            baudctl_q   <= sbw_pkg::RST_ZERO;
            wake_seen_q <= 1'b0;
        end else begin
            if (wr && req.adr == sbw_pkg::ADDR_BAUDCTL) begin
                baudctl_q <= {3'b000, req.dat[4:3], 1'b0, req.dat[1:0]};
                wake_seen_q <= 1'b0;
            end else if (baudctl_q[sbw_pkg::BC_WAKE]) begin
                if (fall)
                    wake_seen_q <= 1'b1;
                else if (rise && wake_seen_q) begin
                    baudctl_q[sbw_pkg::BC_WAKE] <= 1'b0;
                    wake_seen_q <= 1'b0;
                end
            end
        end
    end
    // =========================================================
    // receive flag: set by wake edge, cleared by buffer read, set wins
    always_ff @(posedge clk_i) begin
        if (rst_i)
            rxf_q <= 1'b0;
        else if (baudctl_q[sbw_pkg::BC_WAKE] && fall && !wake_seen_q)
            rxf_q <= 1'b1;
        else if (rd && req.adr == sbw_pkg::ADDR_RXBUF)
            rxf_q <= 1'b0;
    end
    // =========================================================
    // transmit buffer; write fills it, move to shifter empties it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            txbuf_q      <= sbw_pkg::RST_ZERO;
            txbuf_full_q <= 1'b0;
        end else if (wr && req.adr == sbw_pkg::ADDR_TXBUF) begin
            txbuf_q      <= req.dat;
            txbuf_full_q <= 1'b1;
        end else if (load_now) begin
            txbuf_full_q <= 1'b0;
        end
    end
    // =========================================================
    // transmit sequencer
    // async: start, 8/9 data or 12 zeros, stop; sync: two ticks per bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q        <= sbw_pkg::SBW_IDLE;
            shift_q     <= '0;
            bitcnt_q    <= '0;
            half_q      <= 1'b0;
            brk_frame_q <= 1'b0;
        end else begin
            case (st_q)
                sbw_pkg::SBW_IDLE: begin
                    half_q <= 1'b0;
                    if (load_now) begin
                        // one cycle move from buffer into shifter
                        shift_q <= {txctl_q[sbw_pkg::TX_D9], txbuf_q};
                        brk_frame_q <= async_m && txctl_q[sbw_pkg::TX_BRK];
                        st_q <= sbw_pkg::SBW_LOAD;
                    end
                end
                sbw_pkg::SBW_LOAD: begin
                    // start bit in async; first half period in sync
                    if (tick) begin
                        if (sync_m) begin
                            bitcnt_q <= txctl_q[sbw_pkg::TX_NINE] ? 4'd9 : 4'd8;
                            st_q     <= sbw_pkg::SBW_SHIFT;
                        end else if (brk_frame_q) begin
                            bitcnt_q <= sbw_pkg::BREAK_ZEROS;
                            st_q     <= sbw_pkg::SBW_BREAK;
                        end else begin
                            bitcnt_q <= txctl_q[sbw_pkg::TX_NINE] ? 4'd9 : 4'd8;
                            st_q     <= sbw_pkg::SBW_SHIFT;
                        end
                    end
                end
                sbw_pkg::SBW_SHIFT: begin
                    if (tick) begin
                        half_q <= sync_m ? !half_q : 1'b0;
                        if (!sync_m || half_q) begin
                            shift_q  <= {1'b0, shift_q[8:1]};
                            bitcnt_q <= bitcnt_q - 4'd1;
                            if (bitcnt_q == 4'd1)
                                st_q <= sync_m ? sbw_pkg::SBW_IDLE : sbw_pkg::SBW_STOP;
                        end
                    end
                end
                sbw_pkg::SBW_BREAK: begin
                    if (tick) begin
                        bitcnt_q <= bitcnt_q - 4'd1;
                        if (bitcnt_q == 4'd1)
                            st_q <= sbw_pkg::SBW_STOP;
                    end
                end
                sbw_pkg::SBW_STOP: begin
                    if (tick)
                        st_q <= sbw_pkg::SBW_IDLE;
                end
                default: st_q <= sbw_pkg::SBW_IDLE;
            endcase
        end
    end
    // =========================================================
    // pin drivers, all registered
    // sync master owns clock, and data only while transmit is enabled; nothing received while sending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_o    <= 1'b1;
            dt_o    <= 1'b1;
            dt_oe_o <= 1'b0;
            ck_oe_o <= 1'b0;
        end else if (sync_m) begin
            ck_oe_o <= 1'b1;
            // clock leaves idle level only in second half of a bit
            tx_o    <= baudctl_q[sbw_pkg::BC_POL] ^
                       ((st_q == sbw_pkg::SBW_SHIFT) && half_q);
            dt_oe_o <= txctl_q[sbw_pkg::TX_EN];
            dt_o    <= (st_q == sbw_pkg::SBW_SHIFT) ? shift_q[0] : 1'b1;
        end else begin
            ck_oe_o <= async_m && txctl_q[sbw_pkg::TX_EN];
            dt_oe_o <= 1'b0;
            dt_o    <= 1'b1;
            case (st_q)
                sbw_pkg::SBW_LOAD:  tx_o <= 1'b0;
                sbw_pkg::SBW_SHIFT: tx_o <= shift_q[0];
                sbw_pkg::SBW_BREAK: tx_o <= 1'b0;
                default:            tx_o <= 1'b1;
            endcase
        end
    end
    // =========================================================
    // flag outputs; transmit flag ignores its enable
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_int_o <= 1'b0;
            tx_int_o <= 1'b0;
        end else begin
            rx_int_o <= rxf_q;
            tx_int_o <= !txbuf_full_q;
        end
    end
endmodule

/* File: sbw_sva.sv */
// Purpose: port-level assertions for the break, wake and sync master block
// Assumes: one clock domain, divisor set so one bit lasts BIT_CYC clocks
// Notes:   bound to the top module below the checker
`timescale 1ns/1ps
module sbw_sva #(
    parameter int BIT_CYC = 4
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [5:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        rx_i,
    input wire logic        tx_o,
    input wire logic        dt_oe_o,
    input wire logic        ck_oe_o,
    input wire logic        rx_int_o,
    input wire logic        tx_int_o
);
    // ==========================================================
    // helpers
    logic       wr_tx; // write accepted into the transmit buffer
    logic       rd_rx; // read accepted from the receive buffer
    logic [7:0] low_q; // length of the current async low run
    assign wr_tx = cyc_i && stb_i && we_i && ack_o && sel_i[0] && adr_i == sbw_pkg::ADDR_TXBUF;
    assign rd_rx = cyc_i && stb_i && !we_i && ack_o && adr_i == sbw_pkg::ADDR_RXBUF;
    // counts in async mode and in sync mode with transmit disabled; dt_oe_o alone marks the line as a clock
    always_ff @(posedge clk_i) begin
        if (rst_i || tx_o || !ck_oe_o || dt_oe_o) begin
            low_q <= 8'h00;
        end else begin
            low_q <= low_q + 8'h01;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================================
    // bus, reset and line checks
    ack_resp_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    read_pad_a: assert property (ack_o && !we_i |-> dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    reset_pins_a: assert property ($fell(rst_i) |-> tx_o && !ck_oe_o && !dt_oe_o && !rx_int_o)
        else $error("pins not at reset level");
    wake_flag_a: assert property ($rose(rx_int_o) |-> !$past(rx_i, 3))
        else $error("receive flag rose without a falling rx edge");
    wake_clear_a: assert property ($fell(rx_int_o) |-> $past(rd_rx) || $past(rd_rx, 2))
        else $error("receive flag cleared without a buffer read");
    flag_clear_a: assert property ($fell(tx_int_o) |-> $past(wr_tx) || $past(wr_tx, 2)
        || $past(wr_tx, 3))
        else $error("transmit flag cleared without a buffer write");
    break_len_a: assert property (low_q <= 13 * BIT_CYC)
        else $error("low run longer than a break");
    cover property ($rose(rx_int_o));
    cover property (wr_tx);
    cover property (low_q == 13 * BIT_CYC);
endmodule

bind sbw_top sbw_sva #(.BIT_CYC(4)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx_i(rx_i), .tx_o(tx_o), .dt_oe_o(dt_oe_o), .ck_oe_o(ck_oe_o), .rx_int_o(rx_int_o),
    .tx_int_o(tx_int_o));

/* File: sbw_node.sv */
// Purpose: remote serial node watching the tx line and driving rx
// Assumes: BIT clocks per bit; a released line is pulled up
// Notes:   a frame whose stop sample is low is reported as a break
`timescale 1ns/1ps
module sbw_node #(
    parameter int BIT = 4
) (
    input  wire logic  clk_i,
    input  wire logic  line_i, // tx pin level on the wire
    input  wire logic  wake_i, // hold rx low while set
    output logic       rx_o,
    output logic [7:0] byte_o, // last frame data
    output logic       brk_o,  // last frame had a low stop
    output logic [7:0] lo_o,   // longest low run in clocks
    output logic [3:0] nfr_o   // frames seen
);
    // ==========================================================
    logic [7:0] run, sh, t;
    logic [3:0] b;
    logic       busy, arm;
    initial begin
        {run, sh, t, b, busy, arm} = '0;
        {byte_o, brk_o, lo_o, nfr_o} = '0;
    end
    assign rx_o = ~wake_i; // pull-up when not pulling low
    // ==========================================================
    // mid-bit sampler, re-armed only once the line is high again
    always @(posedge clk_i) begin
        run <= line_i ? 8'h00 : run + 8'h01;
        if (line_i && run > lo_o) lo_o <= run;
        if (line_i && !busy) arm <= 1'b1;
        if (!busy && !line_i && arm) begin
            busy <= 1'b1;
            arm <= 1'b0;
            b <= 4'h0;
            t <= 8'(BIT + BIT / 2 - 2);
        end else if (busy && t != 8'h00) begin
            t <= t - 8'h01;
        end else if (busy) begin
            t <= 8'(BIT - 1);
            b <= b + 4'h1;
            if (b == 4'h8) begin
                busy <= 1'b0;
                brk_o <= !line_i;
                byte_o <= sh;
                nfr_o <= nfr_o + 4'h1;
            end else begin
                sh <= {line_i, sh[7:1]};
            end
        end
    end
endmodule

/* File: test_serial_break_wake_sync_master_tx.sv */
// Purpose: self-checking bench for the break, wake and sync master block
// Assumes: divisor 3, so one async bit lasts four clocks and one sync bit eight
// Notes:   register rows first, then wake, break header and sync cases
`timescale 1ns/1ps
module test_serial_break_wake_sync_master_tx;
    typedef struct packed {logic [5:0] a; logic [3:0] s; logic [7:0] d, e;} sbw_row_s;
    // ==========================================================
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [5:0]  adr_i = 6'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, rd;
    logic        ack_o, tx_o, dt_o, dt_oe_o, ck_oe_o, rx_int_o, tx_int_o;
    logic        node_rx, nbrk, wake = 1'b0, p;
    logic [7:0]  nbyte, nlo, sh;
    logic [3:0]  nfr;
    int          n_mismatch = 0, check_count = 0, i, f;
    wire         rx_i = dt_oe_o ? dt_o : node_rx; // shared data pin
    wire         line = ck_oe_o ? tx_o : 1'b1;    // pulled up when released
    sbw_row_s    rows[10] = '{
        '{sbw_pkg::ADDR_TXCTL, 4'h0, 8'hff, sbw_pkg::RST_TXCTL}, // sel 0 write ignored
        '{sbw_pkg::ADDR_RXCTL, 4'h0, 8'hff, 8'h00},
        '{sbw_pkg::ADDR_BAUDCTL, 4'h0, 8'hff, 8'h40},
        '{sbw_pkg::ADDR_ENABLES, 4'h1, 8'h5a, 8'h5a},
        '{sbw_pkg::ADDR_PRIO, 4'h1, 8'h3c, 8'h3c},
        '{sbw_pkg::ADDR_DIVHI, 4'h1, 8'h00, 8'h00},
        '{sbw_pkg::ADDR_DIVLO, 4'h1, 8'h03, 8'h03},
        '{sbw_pkg::ADDR_FLAGS, 4'h1, 8'h00, 8'h10},
        '{sbw_pkg::ADDR_TXCTL, 4'h1, 8'h00, sbw_pkg::RST_TXCTL},
        '{6'h2c, 4'h1, 8'hff, 8'h00}};
    always #5 clk_i = ~clk_i;
    sbw_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rx_i(rx_i), .tx_o(tx_o), .dt_o(dt_o), .dt_oe_o(dt_oe_o), .ck_oe_o(ck_oe_o),
        .rx_int_o(rx_int_o), .tx_int_o(tx_int_o));
    sbw_node #(.BIT(4)) u_node (.clk_i(clk_i), .line_i(line), .wake_i(wake), .rx_o(node_rx),
        .byte_o(nbyte), .brk_o(nbrk), .lo_o(nlo), .nfr_o(nfr));
    // ==========================================================
    // compare, bus cycle and closing tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // holds the request until ack is seen, takes data at that edge
    task automatic wb(input logic [5:0] a, input logic w, input logic [3:0] s,
                      input logic [7:0] d);
        int n;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i} <= {2'b11, w, a, s};
        dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = dat_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
        wb(a, 1'b0, 4'h1, 8'h00);
        check(rd, {24'h0, e});
    endtask
    task automatic waitfr(input logic [3:0] n);
        for (int k = 0; k < 3000 && nfr !== n; k++) @(negedge clk_i);
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog, far beyond the well under a thousand clocks the run needs
    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end
    // ==========================================================
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(negedge clk_i);
        check({tx_o, ck_oe_o, tx_int_o}, 3'b101);
        foreach (rows[i]) begin
            wb(rows[i].a, 1'b1, rows[i].s, rows[i].d);
            rdchk(rows[i].a, rows[i].e);
        end
        // wake: low rx sets the flag, rising edge clears the enable
        wb(sbw_pkg::ADDR_BAUDCTL, 1'b1, 4'h1, 8'h02);
        rdchk(sbw_pkg::ADDR_BAUDCTL, 8'h02);
        wake <= 1'b1;
        repeat (20) @(posedge clk_i);
        check(rx_int_o, 1'b1);
        rdchk(sbw_pkg::ADDR_BAUDCTL, 8'h02);
        rdchk(sbw_pkg::ADDR_FLAGS, 8'h30);
        wake <= 1'b0;
        repeat (10) @(posedge clk_i);
        rdchk(sbw_pkg::ADDR_BAUDCTL, 8'h40);
        rdchk(sbw_pkg::ADDR_RXBUF, 8'h00);
        rdchk(sbw_pkg::ADDR_FLAGS, 8'h10);
        // break header: dummy byte starts the break, sync byte queued behind
        wb(sbw_pkg::ADDR_RXCTL, 1'b1, 4'h1, 8'h80);
        wb(sbw_pkg::ADDR_TXCTL, 1'b1, 4'h1, 8'h28);
        rdchk(sbw_pkg::ADDR_TXCTL, 8'h2a);
        wb(sbw_pkg::ADDR_TXBUF, 1'b1, 4'h1, 8'ha7);
        wb(sbw_pkg::ADDR_TXBUF, 1'b1, 4'h1, 8'h55);
        rdchk(sbw_pkg::ADDR_TXCTL, 8'h28);
        check(tx_int_o, 1'b0);
        waitfr(4'h1);
        check({nbrk, nbyte}, 9'h100);
        waitfr(4'h2);
        check({nbrk, nbyte, nlo}, {1'b0, 8'h55, 8'd52});
        repeat (20) @(posedge clk_i);
        rdchk(sbw_pkg::ADDR_TXCTL, 8'h22);
        check(tx_int_o, 1'b1);
        // sync master: nine clock periods, data stable at the mid-bit edge
        wb(sbw_pkg::ADDR_BAUDCTL, 1'b1, 4'h1, 8'h11);
        wb(sbw_pkg::ADDR_TXCTL, 1'b1, 4'h1, 8'hf1);
        repeat (4) @(negedge clk_i);
        check({dt_oe_o, ck_oe_o, tx_o}, 3'b111);
        wb(sbw_pkg::ADDR_TXBUF, 1'b1, 4'h1, 8'hc3);
        {f, sh, p} = {32'd0, 8'h00, tx_o};
        repeat (300) begin
            @(negedge clk_i);
            if (p && !tx_o) begin
                sh = {dt_o, sh[7:1]};
                f++;
            end
            p = tx_o;
        end
        check({f[7:0], sh, tx_o, rx_int_o}, {8'd9, 8'he1, 2'b10});
        wb(sbw_pkg::ADDR_BAUDCTL, 1'b1, 4'h1, 8'h00);
        repeat (4) @(negedge clk_i);
        check(tx_o, 1'b0);
        conclude();
    end
endmodule
